/* src/eesel_front.sv */
// two-wire bus slave front end: select decode, acknowledge and byte handshakes
//
// Contract
// - main array holds 64K byte-wide locations, reached by two address bytes
// - type code 1010 in the select byte selects the main array
// - with the page option, type code 1011 selects the identification page
// - identification page is 128 bytes, writable until locked, then read-only
// - the front end is only a slave; all progress follows the master clock
// - start is followed by select code plus direction bit, closed by acknowledge slot
// - when receiving, acknowledge in the ninth bit period after each byte
// - the serial clock is the only strobe for every bit in and out
// - data line is open drain: pulled low or released, never driven high
// - three select pins give select bits b3..b1, top pin to b3
// - unconnected select pins read low, expecting 0,0,0
// - select byte arrives most significant bit first
// - direction bit 1 means read, 0 means write
// - on select mismatch: no acknowledge, release, standby until next start
// - write protect high: select and address acknowledged, write data refused
`timescale 1ns/1ns
`default_nettype none
module eesel_front
#(
    parameter bit HAS_ID_PAGE = 1'b1,
    parameter int BUF_DEPTH = eesel_pkg::BUF_DEPTH_DEF
)
(
    // system
    input wire logic clk,
    input wire logic rstn,
    // two-wire bus
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // straps and protection
    input wire logic [2:0] select_addr_pins,
    input wire logic write_protect_in,
    input wire logic id_page_locked,
    // select outcome
    output logic sel_match_pulse,
    output logic sel_rw,
    output logic sel_id_page,
    output logic xfer_active,
    output logic stop_pulse,
    // received address and data bytes
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [7:0] rx_data,
    output logic [1:0] rx_kind,
    // bytes to send on a read
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready
);
    import eesel_pkg::*;

    // pins: scl, sda, write protect, three select pins
    localparam int NPIN = 6;

    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] s1_r;
    logic [NPIN-1:0] s2_r;
    logic [NPIN-1:0] s3_r;
    logic [NPIN-1:0] filt_r;
    logic scl_f;
    logic sda_f;
    logic wp_f;
    logic [2:0] pins_f;
    logic scl_q_r;
    logic sda_q_r;
    logic scl_rise;
    logic scl_fall;
    logic start_evt;
    logic stop_evt;

    eesel_state_t state_r;
    eesel_kind_t kind_r;
    logic [2:0] bit_cnt_r;
    logic [6:0] shift_r;
    logic [7:0] byte_in;
    logic [7:0] tx_shift_r;
    logic ack_go_r;
    logic mack_r;
    logic sda_oe_n_r;
    logic sel_match_r;
    logic sel_rw_r;
    logic sel_id_r;
    logic active_r;
    logic stop_r;
    logic rx8_evt;
    logic load_evt;
    logic [7:0] load_byte;
    logic hit_mem;
    logic hit_id;
    logic accept_pre;
    logic accept;

    eesel_stream_if #(.WIDTH(WORD_W)) push_if ();
    eesel_stream_if #(.WIDTH(WORD_W)) pop_if ();

    // select byte match against straps for one type code
    function automatic logic select_hit(input logic [7:0] b, input logic [3:0] ty,
                                        input logic [2:0] pins);
        select_hit = (b[SEL_TYPE_MSB:SEL_TYPE_LSB] == ty) &&
                     (b[SEL_PINS_MSB:SEL_PINS_LSB] == pins);
    endfunction

    // pin synchronisers; a bit changes once stages two and three agree,
    // which also rejects single-sample glitches on the bus lines
    assign pin_raw = {select_addr_pins, write_protect_in, sda_in, scl_in};

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s1_r <= {3'h0, 1'b0, LINE_RST, LINE_RST};
            s2_r <= {3'h0, 1'b0, LINE_RST, LINE_RST};
            s3_r <= {3'h0, 1'b0, LINE_RST, LINE_RST};
            filt_r <= {3'h0, 1'b0, LINE_RST, LINE_RST};
        end
        else
        begin
            s1_r <= pin_raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
            filt_r <= (s2_r & ~(s2_r ^ s3_r)) | (filt_r & (s2_r ^ s3_r));
        end
    end

    assign scl_f = filt_r[0];
    assign sda_f = filt_r[1];
    assign wp_f = filt_r[2];
    // floating straps are pulled low at the pad, so reset value 000 matches
    assign pins_f = filt_r[5:3];

    // edges of the filtered bus lines
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            scl_q_r <= LINE_RST;
            sda_q_r <= LINE_RST;
        end
        else
        begin
            scl_q_r <= scl_f;
            sda_q_r <= sda_f;
        end
    end

    assign scl_rise = scl_f && !scl_q_r;
    assign scl_fall = !scl_f && scl_q_r;
    assign start_evt = scl_f && scl_q_r && sda_q_r && !sda_f;
    assign stop_evt = scl_f && scl_q_r && !sda_q_r && sda_f;

    // byte being completed on the eighth rising edge, msb first
    assign byte_in = {shift_r, sda_f};
    assign rx8_evt = (state_r == ST_RX) && scl_rise && (bit_cnt_r == BIT_LAST);
    assign hit_mem = select_hit(byte_in, TYPE_MEM, pins_f);
    assign hit_id = HAS_ID_PAGE && select_hit(byte_in, TYPE_ID_PAGE, pins_f);

    // acceptance before buffer space is considered
    always_comb
    begin
        accept_pre = 1'b0;
        unique case (kind_r)
            KIND_SEL: accept_pre = hit_mem || hit_id;
            KIND_ADDR_HI, KIND_ADDR_LO: accept_pre = 1'b1;
            KIND_DATA: accept_pre = !wp_f && !(sel_id_r && id_page_locked);
        endcase
    end

    // a full buffer refuses the byte rather than losing it
    assign accept = accept_pre && ((kind_r == KIND_SEL) || push_if.ready);
    assign push_if.valid = rx8_evt && (kind_r != KIND_SEL) && accept_pre;
    assign push_if.data = {kind_r, byte_in};

    eesel_buf #(.WIDTH(WORD_W), .DEPTH(BUF_DEPTH)) u_buf (
        .clk(clk),
        .rstn(rstn),
        .in_s(push_if.snk),
        .out_s(pop_if.src)
    );

    assign rx_valid = pop_if.valid;
    assign pop_if.ready = rx_ready;
    assign rx_kind = pop_if.data[WORD_W-1:DATA_BITS];
    assign rx_data = pop_if.data[DATA_BITS-1:0];

    // next read byte is fetched on the falling edge that opens its first bit
    assign load_evt = scl_fall && !start_evt &&
                      (((state_r == ST_ACK) && (kind_r == KIND_SEL) && (sel_rw_r == RW_READ)) ||
                       ((state_r == ST_MACK) && mack_r));
    assign load_byte = tx_valid ? tx_data : IDLE_BYTE;
    assign tx_ready = load_evt;

    // bit-level sequencer, advanced by scl edges and by start and stop conditions
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_r <= ST_IDLE;
            kind_r <= KIND_SEL;
            bit_cnt_r <= BIT_FIRST;
            ack_go_r <= 1'b0;
            mack_r <= 1'b0;
        end
        else if (start_evt)
        begin
            state_r <= ST_RX;
            kind_r <= KIND_SEL;
            bit_cnt_r <= BIT_FIRST;
        end
        else if (stop_evt)
        begin
            state_r <= ST_IDLE;
        end
        else
        begin
            unique case (state_r)
                ST_IDLE, ST_WAIT:
                begin
                end
                ST_RX:
                    if (scl_rise)
                    begin
                        bit_cnt_r <= bit_cnt_r + 1'b1;
                        if (bit_cnt_r == BIT_LAST)
                        begin
                            state_r <= ST_RXEND;
                            ack_go_r <= accept;
                        end
                    end
                ST_RXEND:
                    if (scl_fall)
                    begin
                        state_r <= ack_go_r ? ST_ACK : ST_WAIT;
                    end
                ST_ACK:
                    if (scl_fall)
                    begin
                        bit_cnt_r <= BIT_FIRST;
                        if (load_evt)
                        begin
                            state_r <= ST_TX;
                        end
                        else
                        begin
                            state_r <= ST_RX;
                            unique case (kind_r)
                                KIND_SEL: kind_r <= KIND_ADDR_HI;
                                KIND_ADDR_HI: kind_r <= KIND_ADDR_LO;
                                KIND_ADDR_LO, KIND_DATA: kind_r <= KIND_DATA;
                            endcase
                        end
                    end
                ST_TX:
                    if (scl_fall)
                    begin
                        bit_cnt_r <= bit_cnt_r + 1'b1;
                        if (bit_cnt_r == BIT_LAST)
                        begin
                            state_r <= ST_MACK;
                        end
                    end
                ST_MACK:
                begin
                    if (scl_rise)
                    begin
                        mack_r <= !sda_f;
                    end
                    if (scl_fall)
                    begin
                        bit_cnt_r <= BIT_FIRST;
                        state_r <= mack_r ? ST_TX : ST_WAIT;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // receive shifter samples on scl rising edges only
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            shift_r <= '0;
        end
        else if ((state_r == ST_RX) && scl_rise && !start_evt)
        begin
            shift_r <= byte_in[6:0];
        end
    end

    // transmit shifter moves on scl falling edges only
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tx_shift_r <= IDLE_BYTE;
        end
        else if (load_evt)
        begin
            tx_shift_r <= load_byte;
        end
        else if ((state_r == ST_TX) && scl_fall)
        begin
            tx_shift_r <= {tx_shift_r[6:0], 1'b1};
        end
    end

    // open-drain data line: only ever pulled low or released
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sda_oe_n_r <= SDA_OE_N_RST;
        end
        else if (start_evt || stop_evt)
        begin
            sda_oe_n_r <= 1'b1;
        end
        else if (load_evt)
        begin
            sda_oe_n_r <= load_byte[7];
        end
        else if (scl_fall)
        begin
            unique case (state_r)
                ST_RXEND: sda_oe_n_r <= !ack_go_r;
                ST_ACK: sda_oe_n_r <= 1'b1;
                ST_TX: sda_oe_n_r <= (bit_cnt_r == BIT_LAST) ? 1'b1 : tx_shift_r[6];
                ST_MACK: sda_oe_n_r <= 1'b1;
                default: sda_oe_n_r <= sda_oe_n_r;
            endcase
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe_n = sda_oe_n_r;

    // select direction and page held until the next accepted select byte; match flag pulses one cycle
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sel_match_r <= 1'b0;
            sel_rw_r <= 1'b0;
            sel_id_r <= 1'b0;
        end
        else
        begin
            sel_match_r <= rx8_evt && (kind_r == KIND_SEL) && accept;
            if (rx8_evt && (kind_r == KIND_SEL) && accept)
            begin
                sel_rw_r <= byte_in[SEL_RW_BIT];
                sel_id_r <= hit_id;
            end
        end
    end

    // transfer status seen by the memory core
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            active_r <= 1'b0;
            stop_r <= 1'b0;
        end
        else
        begin
            stop_r <= stop_evt && (state_r != ST_IDLE);
            active_r <= !start_evt && !stop_evt &&
                        ((state_r == ST_ACK) || (state_r == ST_TX) || (state_r == ST_MACK) ||
                         (((state_r == ST_RX) || (state_r == ST_RXEND)) &&
                          (kind_r != KIND_SEL)));
        end
    end

    assign sel_match_pulse = sel_match_r;
    assign sel_rw = sel_rw_r;
    assign sel_id_page = sel_id_r;
    assign xfer_active = active_r;
    assign stop_pulse = stop_r;
endmodule
`default_nettype wire

/* src/eesel_pkg.sv */
// shared constants and types for the two-wire memory select/acknowledge front end
package eesel_pkg;

    // memory geometry seen through this front end
    localparam int MEM_BYTES = 65536;
    localparam int ID_PAGE_BYTES = 128;
    localparam int DATA_BITS = 8;
    localparam int ADDR_BYTES = 2;

    // select byte layout, most significant bit first on the wire
    localparam int SEL_TYPE_MSB = 7;
    localparam int SEL_TYPE_LSB = 4;
    localparam int SEL_PINS_MSB = 3;
    localparam int SEL_PINS_LSB = 1;
    localparam int SEL_RW_BIT = 0;
    localparam logic [3:0] TYPE_MEM = 4'hA;
    localparam logic [3:0] TYPE_ID_PAGE = 4'hB;
    localparam logic RW_READ = 1'b1;

    // counts and values after reset
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [7:0] IDLE_BYTE = 8'hFF;
    localparam logic SDA_OE_N_RST = 1'b1;
    localparam logic LINE_RST = 1'b1;
    localparam int BUF_DEPTH_DEF = 2;

    // what a received byte is
    typedef enum logic [1:0] {
        KIND_SEL = 2'b00,
        KIND_ADDR_HI = 2'b01,
        KIND_ADDR_LO = 2'b10,
        KIND_DATA = 2'b11
    } eesel_kind_t;

    localparam int WORD_W = 2 + DATA_BITS;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX = 3'b001,
        ST_RXEND = 3'b010,
        ST_ACK = 3'b011,
        ST_TX = 3'b100,
        ST_MACK = 3'b101,
        ST_WAIT = 3'b110
    } eesel_state_t;

endpackage

/* src/eesel_stream_if.sv */
// valid/ready word stream between the bus engine and its receive buffer
`timescale 1ns/1ns
`default_nettype none
interface eesel_stream_if #(parameter int WIDTH = 10);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* src/eesel_buf.sv */
// DEPTH-entry flip-flop buffer, two entries by default, with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module eesel_buf
#(
    parameter int WIDTH = 10,
    parameter int DEPTH = 2
)
(
    // system
    input wire logic clk,
    input wire logic rstn,
    // streams
    eesel_stream_if.snk in_s,
    eesel_stream_if.src out_s
);
    import eesel_pkg::*;

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0] wr_ptr_r;
    logic [PW-1:0] rd_ptr_r;
    logic [CW-1:0] count_r;
    logic push;
    logic pop;

    assign in_s.ready = (count_r != CNT_FULL);
    assign out_s.valid = (count_r != '0);
    assign out_s.data = mem_r[rd_ptr_r];
    assign push = in_s.valid && in_s.ready;
    assign pop = out_s.valid && out_s.ready;

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem_r[wr_ptr_r] <= in_s.data;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_r <= (wr_ptr_r == PTR_LAST) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_r <= (rd_ptr_r == PTR_LAST) ? '0 : rd_ptr_r + 1'b1;
            end
            if (push && !pop)
            begin
                count_r <= count_r + 1'b1;
            end
            else if (pop && !push)
            begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* verification/eesel_front_assertions.sv */
// concurrent checks on the ports of the select/acknowledge front end
`timescale 1ns/1ns
`default_nettype none
module eesel_front_chk
(
    // system
    input wire logic clk,
    input wire logic rstn,
    // two-wire bus
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    // select outcome
    input wire logic sel_match_pulse,
    input wire logic sel_rw,
    input wire logic xfer_active,
    input wire logic stop_pulse,
    // streams
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire logic [7:0] rx_data,
    input wire logic [1:0] rx_kind,
    input wire logic tx_ready
);
    import eesel_pkg::*;
    // nine bit periods of the bench bus rate; a slower bus needs a larger bound
    localparam int LOW_MAX = 120;
    // scl high time plus sync lag at the bench bus rate; a slower bus needs a larger bound
    localparam int ACK_MAX = 12;
    logic [7:0] low_cnt_r;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            low_cnt_r <= 8'h00;
        else if (sda_oe_n)
            low_cnt_r <= 8'h00;
        else if (low_cnt_r != 8'hFF)
            low_cnt_r <= low_cnt_r + 8'h01;
    end
    a_never_drive_high: assert property (sda_out == 1'b0)
        else $error("data line driven to a non-low value");
    a_pull_scl_low: assert property ($fell(sda_oe_n) |-> !scl_in)
        else $error("data line pulled while bus clock high");
    a_match_single: assert property (sel_match_pulse |=> !sel_match_pulse)
        else $error("select pulse longer than one cycle");
    a_match_enters: assert property (sel_match_pulse |->
        ##[1:ACK_MAX] (xfer_active && !sda_oe_n))
        else $error("accepted select did not open its acknowledge slot");
    a_stop_leaves: assert property (stop_pulse |-> ##[0:2] !xfer_active)
        else $error("transfer still active after stop");
    a_rx_kind_legal: assert property (rx_valid |-> rx_kind != KIND_SEL)
        else $error("select byte leaked into the receive stream");
    a_rx_word_holds: assert property (rx_valid && !rx_ready |=>
        rx_valid && $stable(rx_data) && $stable(rx_kind))
        else $error("stalled receive word changed or vanished");
    a_tx_in_read: assert property (tx_ready |-> sel_rw && xfer_active)
        else $error("read byte taken outside a read transfer");
    a_ack_released: assert property (low_cnt_r <= LOW_MAX)
        else $error("data line held low too long");
endmodule
bind eesel_front eesel_front_chk u_chk (.clk(clk), .rstn(rstn), .scl_in(scl_in),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .sel_match_pulse(sel_match_pulse),
    .sel_rw(sel_rw), .xfer_active(xfer_active), .stop_pulse(stop_pulse),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .rx_kind(rx_kind),
    .tx_ready(tx_ready));
`default_nettype wire

/* verification/eesel_master.sv */
// two-wire bus master model driving clock and data toward the front end
`timescale 1ns/1ns
`default_nettype none
module eesel_master
(
    // bus
    output logic scl,
    output logic sda_rel,
    input wire logic sda_line
);
    initial
    begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    // also serves as repeated start when called with the clock low
    task automatic start();
        sda_rel = 1'b1;
        #20 scl = 1'b1;
        #62 sda_rel = 1'b0;
        #62 scl = 1'b0;
    endtask
    // data moves only while the clock is low; 125 ns per bit
    task automatic bit_io(input logic b, output logic r);
        #20 sda_rel = b;
        #42 scl = 1'b1;
        #60 r = sda_line;
        #3 scl = 1'b0;
    endtask
    task automatic wbyte(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(v[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic rbyte(output logic [7:0] v, input logic mack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, v[i]);
        bit_io(!mack, r);
    endtask
    task automatic stop();
        #20 sda_rel = 1'b0;
        #42 scl = 1'b1;
        #62 sda_rel = 1'b1;
    endtask
endmodule
`default_nettype wire

/* verification/tb.sv */
// self-checking bench for the two-wire select/acknowledge front end
`timescale 1ns/1ns
`default_nettype none
module tb;
    import eesel_pkg::*;
    logic clk, rstn, scl_in, sda_rel, wp, locked, rx_ready, tx_valid, stall;
    logic sda_out, sda_oe_n, sel_match_pulse, sel_rw, sel_id_page, xfer_active;
    logic stop_pulse, rx_valid, tx_ready;
    logic [2:0] pins;
    logic [7:0] rx_data, tx_data;
    logic [1:0] rx_kind;
    logic [3:0] tbl [3];
    logic [9:0] rxq [$];
    logic [7:0] txq [$];
    int fails, comparisons;
    wire logic sda_in;
    // pull-up: line is high unless someone pulls it low
    assign sda_in = sda_rel & (sda_oe_n | sda_out);
    eesel_front #(.HAS_ID_PAGE(1'b1), .BUF_DEPTH(2)) u_eesel_front (.clk(clk), .rstn(rstn),
        .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .select_addr_pins(pins), .write_protect_in(wp), .id_page_locked(locked),
        .sel_match_pulse(sel_match_pulse), .sel_rw(sel_rw), .sel_id_page(sel_id_page),
        .xfer_active(xfer_active), .stop_pulse(stop_pulse), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_data(rx_data), .rx_kind(rx_kind), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready));
    eesel_master u_eesel_master (.scl(scl_in), .sda_rel(sda_rel), .sda_line(sda_in));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
        comparisons++;
        if (g !== e)
        begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk)
    begin
        if (rx_valid === 1'b1 && rx_ready === 1'b1)
            chk("rx_word", rxq.size() ? rxq.pop_front() : 10'h000, {rx_kind, rx_data});
        if (tx_ready === 1'b1)
            txq.push_back(tx_valid ? tx_data : IDLE_BYTE);
        #1;
        rx_ready = !stall && ($urandom % 4 != 0);
        tx_valid = 1'($urandom);
        tx_data = 8'($urandom);
    end
    task automatic drain();
        for (int i = 0; i < 60 && rxq.size() != 0; i++)
            @(posedge clk);
        chk("rx_drained", 10'h000, 10'(rxq.size()));
    endtask
    task automatic wr(input logic [7:0] sel, input int n);
        logic a, ok;
        logic [7:0] d;
        sel[0] = 1'b0;
        ok = (sel[7:4] == TYPE_MEM || sel[7:4] == TYPE_ID_PAGE) && sel[3:1] == pins;
        u_eesel_master.start();
        u_eesel_master.wbyte(sel, a);
        chk("sel_ack", 10'(ok), 10'(a));
        if (ok)
            chk("sel_flags", 10'({sel[4], 1'b0}), 10'({sel_id_page, sel_rw}));
        for (int i = 0; i < n; i++)
        begin
            d = 8'($urandom);
            // a full buffer refuses only once both address words sit unread
            if (i > 1)
                ok = ok && !wp && !(sel[4] && locked) && !stall;
            // expectation goes in first: the consumer may pop before the ack slot ends
            if (ok)
                rxq.push_back({i > 1 ? KIND_DATA : (i ? KIND_ADDR_LO : KIND_ADDR_HI), d});
            u_eesel_master.wbyte(d, a);
            chk("byte_ack", 10'(ok), 10'(a));
        end
        u_eesel_master.stop();
    endtask
    task automatic rd(input logic [3:0] ty, input int n);
        logic a;
        logic [7:0] d;
        txq.delete();
        u_eesel_master.start();
        u_eesel_master.wbyte({ty, pins, RW_READ}, a);
        chk("rd_sel_ack", 10'h001, 10'(a));
        chk("rd_flags", 10'({ty[0], 1'b1}), 10'({sel_id_page, sel_rw}));
        for (int i = 0; i < n; i++)
        begin
            u_eesel_master.rbyte(d, i < n - 1);
            chk("rd_byte", txq.size() ? {2'b00, txq.pop_front()} : 10'h3FF, 10'(d));
        end
        u_eesel_master.stop();
    endtask
    initial
    begin
        #900000;
        fails++;
        tally_and_finish();
    end
    initial
    begin
        logic [7:0] sel;
        logic r;
        rstn = 1'b0;
        pins = 3'h0;
        wp = 1'b0;
        locked = 1'b0;
        stall = 1'b0;
        tbl = '{TYPE_MEM, TYPE_ID_PAGE, 4'h5};
        void'($urandom(98));
        repeat (6) @(posedge clk);
        #1 rstn = 1'b1;
        repeat (5) @(posedge clk);
        for (int t = 0; t < 12; t++)
        begin
            @(posedge clk) #1;
            pins = t ? 3'($urandom) : 3'h0;
            wp = 1'($urandom);
            locked = 1'($urandom);
            sel = 8'($urandom);
            sel[7:4] = tbl[t % 3];
            if (t % 2 == 0)
                sel[3:1] = pins;
            wr(sel, t % 5);
            drain();
        end
        for (int t = 0; t < 3; t++)
            rd(t == 1 ? TYPE_ID_PAGE : TYPE_MEM, 3 - t);
        // write protect off, so the stall case below can only refuse for lack of space
        @(posedge clk) #1 wp = 1'b0;
        u_eesel_master.start();
        repeat (3) u_eesel_master.bit_io(1'b1, r);
        wr({TYPE_MEM, pins, 1'b0}, 4);
        drain();
        @(posedge clk) #1 stall = 1'b1;
        repeat (3) @(posedge clk);
        wr({TYPE_MEM, pins, 1'b0}, 3);
        @(posedge clk) #1 stall = 1'b0;
        drain();
        tally_and_finish();
    end
endmodule
`default_nettype wire
